// *** core/pak_top.v ***
`timescale 1ns/100ps
`default_nettype none
`include "pak_regs.vh"

module pak_top #(
  parameter AW = 12
) (
  // Clock and reset
  input  wire          REF_CLK,
  input  wire          ARST_N,
  // AXI4-Lite write channels
  input  wire [AW-1:0] S_AXI_AWADDR,
  input  wire          S_AXI_AWVALID,
  output reg           S_AXI_AWREADY,
  input  wire [31:0]   S_AXI_WDATA,
  input  wire [3:0]    S_AXI_WSTRB,
  input  wire          S_AXI_WVALID,
  output reg           S_AXI_WREADY,
  output reg  [1:0]    S_AXI_BRESP,
  output reg           S_AXI_BVALID,
  input  wire          S_AXI_BREADY,
  // AXI4-Lite read channels
  input  wire [AW-1:0] S_AXI_ARADDR,
  input  wire          S_AXI_ARVALID,
  output reg           S_AXI_ARREADY,
  output reg  [31:0]   S_AXI_RDATA,
  output reg  [1:0]    S_AXI_RRESP,
  output reg           S_AXI_RVALID,
  input  wire          S_AXI_RREADY,
  // Core side, same clock
  input  wire          IDLE_MODE,
  input  wire          POWER_DOWN,
  input  wire          T0_OVERFLOW,
  input  wire [1:0]    P2_LATCH,
  // Pins and straps, asynchronous
  input  wire [7:0]    P0_PIN,
  input  wire          RC_OSC_SEL,
  // Port pin drive
  output reg  [1:0]    P2_OUT,
  output reg  [1:0]    P2_OE,
  output reg  [1:0]    P2_WEAK_PU,
  output reg           P1_2_OUT,
  output reg           P1_2_OE,
  output reg  [2:0]    SCHMITT_SEL,
  // Keypad, wake and interrupt
  output reg           KEYPAD_IRQ_REQ,
  output reg           WAKE,
  output reg           PD_WAKE,
  output reg           IRQ
);

  // Register selects
  localparam [2:0] SEL_NONE = 3'h0;
  localparam [2:0] SEL_KPE  = 3'h1;
  localparam [2:0] SEL_P2A  = 3'h2;
  localparam [2:0] SEL_PORT2_MODE_SECOND = 3'h3;
  localparam [2:0] SEL_AUX  = 3'h4;
  localparam [2:0] SEL_STAT = 3'h5;
  localparam [2:0] SEL_MASK = 3'h6;

  // Write path states, one-hot
  localparam [2:0] WS_IDLE = 3'b001;
  localparam [2:0] WS_HOLD = 3'b010;
  localparam [2:0] WS_RESP = 3'b100;

  reg  [7:0]    keypad_pin_enable;
  reg  [7:0]    port2_aux_mode;
  reg  [7:0]    port2_mode_second;
  reg           keypad_flag;
  reg           keypad_irq_en;
  reg  [1:0]    irq_stat;
  reg  [1:0]    irq_mask;
  reg           t0_toggle;
  reg  [2:0]    wstate;
  reg           aw_held;
  reg           w_held;
  reg  [AW-1:0] aw_addr;
  reg  [7:0]    w_byte;
  reg           w_lane0;
  wire [7:0]    p0_sync;
  wire          rc_sync;
  wire          clk_div_out;
  wire          key_low;
  wire          pd_async_low;
  wire          wr_fire;
  wire [2:0]    wr_sel;
  wire          wr_en;
  reg  [1:0]    next_p2_out;
  reg  [1:0]    next_p2_oe;
  reg  [1:0]    next_p2_pu;
  integer       i;
  integer       j;

  // Maps a byte address onto a register select
  function [2:0] reg_sel;
    input [AW-1:0] addr;
    begin
      case (addr[9:2])
        `PAK_IDX_KEYPAD_EN: reg_sel = SEL_KPE;
        `PAK_IDX_P2_AUX:    reg_sel = SEL_P2A;
        `PAK_IDX_P2_MODE2:  reg_sel = SEL_PORT2_MODE_SECOND;
        `PAK_IDX_AUX_CTRL1: reg_sel = SEL_AUX;
        `PAK_IDX_IRQ_STAT:  reg_sel = SEL_STAT;
        `PAK_IDX_IRQ_MASK:  reg_sel = SEL_MASK;
        default:            reg_sel = SEL_NONE;
      endcase
      if (addr[AW-1:10] != {(AW-10){1'b0}})
        reg_sel = SEL_NONE;
    end
  endfunction

  pak_sync #(.W(8)) u_p0_sync (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .d      (P0_PIN),
    .q      (p0_sync)
  );

  // Oscillator strap is a level from outside the clock domain
  pak_sync #(.W(1)) u_rc_sync (
    .clk    (REF_CLK),
    .arst_n (ARST_N),
    .d      (RC_OSC_SEL),
    .q      (rc_sync)
  );

  pak_clkdiv u_clkdiv (
    .clk     (REF_CLK),
    .arst_n  (ARST_N),
    .enable  (port2_aux_mode[`PAK_CLOCK_OUT_ENABLE_BIT] & rc_sync),
    .clk_out (clk_div_out)
  );

  // keypad low detect on enabled pins
  assign key_low = keypad_irq_en &
                   (|(~p0_sync[`PAK_KPE_MSB:`PAK_KPE_LSB] & keypad_pin_enable[`PAK_KPE_MSB:`PAK_KPE_LSB]));

  // raw pins, so a low is seen while the clock is stopped
  assign pd_async_low = POWER_DOWN & keypad_irq_en &
                        (|(~P0_PIN[`PAK_KPE_MSB:`PAK_KPE_LSB] & keypad_pin_enable[`PAK_KPE_MSB:`PAK_KPE_LSB]));

  assign wr_fire = wstate[1] & aw_held & w_held;
  assign wr_sel  = reg_sel(aw_addr);
  assign wr_en   = wr_fire & w_lane0;

  // Write address and data are taken in either order, then answered once both are in
  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wstate        <= WS_IDLE;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= {AW{1'b0}};
      w_byte        <= 8'h00;
      w_lane0       <= 1'b0;
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `PAK_RESP_OKAY;
    end
    else
    begin
      case (wstate)
        WS_IDLE:
        begin
          S_AXI_AWREADY <= 1'b1;
          S_AXI_WREADY  <= 1'b1;
          wstate        <= WS_HOLD;
        end
        WS_HOLD:
        begin
          if (S_AXI_AWVALID & S_AXI_AWREADY)
          begin
            aw_held       <= 1'b1;
            aw_addr       <= S_AXI_AWADDR;
            S_AXI_AWREADY <= 1'b0;
          end
          if (S_AXI_WVALID & S_AXI_WREADY)
          begin
            w_held       <= 1'b1;
            w_byte       <= S_AXI_WDATA[7:0];
            w_lane0      <= S_AXI_WSTRB[0];
            S_AXI_WREADY <= 1'b0;
          end
          if (wr_fire)
          begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= (wr_sel == SEL_NONE) ? `PAK_RESP_SLVERR : `PAK_RESP_OKAY;
            wstate       <= WS_RESP;
          end
        end
        WS_RESP:
        begin
          if (S_AXI_BREADY)
          begin
            S_AXI_BVALID  <= 1'b0;
            S_AXI_AWREADY <= 1'b1;
            S_AXI_WREADY  <= 1'b1;
            wstate        <= WS_HOLD;
          end
        end
        default:
        begin
          wstate <= WS_IDLE;
        end
      endcase
    end
  end

  // Read path; data are captured with the address, so the answer is one cycle later
  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `PAK_RESP_OKAY;
    end
    else if (S_AXI_RVALID)
    begin
      if (S_AXI_RREADY)
      begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
    else if (S_AXI_ARVALID & S_AXI_ARREADY)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= `PAK_RESP_OKAY;
      case (reg_sel(S_AXI_ARADDR))
        SEL_KPE:  S_AXI_RDATA <= {24'h000000, keypad_pin_enable};
        SEL_P2A:  S_AXI_RDATA <= {24'h000000, port2_aux_mode};
        SEL_PORT2_MODE_SECOND: S_AXI_RDATA <= {24'h000000, port2_mode_second};
        SEL_AUX:  S_AXI_RDATA <= {24'h000000, keypad_flag, 6'h00, keypad_irq_en};
        SEL_STAT: S_AXI_RDATA <= {30'h00000000, irq_stat};
        SEL_MASK: S_AXI_RDATA <= {30'h00000000, irq_mask};
        default:
        begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= `PAK_RESP_SLVERR;
        end
      endcase
    end
    else
    begin
      S_AXI_ARREADY <= 1'b1;
    end
  end

  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      keypad_pin_enable <= `PAK_RST_KEYPAD_EN;
      port2_aux_mode    <= `PAK_RST_P2_AUX;
      port2_mode_second <= `PAK_RST_P2_MODE2;
      keypad_irq_en     <= 1'b0;
      irq_mask          <= `PAK_RST_IRQ;
    end
    else if (wr_en)
    begin
      // only bits 6 to 3 are kept
      if (wr_sel == SEL_KPE)
        keypad_pin_enable <= w_byte & `PAK_KPE_MASK;
      if (wr_sel == SEL_P2A)
        port2_aux_mode <= w_byte;
      if (wr_sel == SEL_PORT2_MODE_SECOND)
        port2_mode_second <= w_byte;
      if (wr_sel == SEL_AUX)
        keypad_irq_en <= w_byte[`PAK_KIE_BIT];
      if (wr_sel == SEL_MASK)
        irq_mask <= w_byte[1:0];
    end
  end

  // flag cleared only by a software zero; a pin low in the same cycle wins
  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      keypad_flag <= 1'b0;
    else if (key_low)
      keypad_flag <= 1'b1;
    else if (wr_en & (wr_sel == SEL_AUX) & ~w_byte[`PAK_KBF_BIT])
      keypad_flag <= 1'b0;
  end

  // Sticky interrupt status, write one to clear, a new event beats the clear
  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      irq_stat <= `PAK_RST_IRQ;
    else
    begin
      for (j = 0; j < 2; j = j + 1)
        if (wr_en & (wr_sel == SEL_STAT) & w_byte[j])
          irq_stat[j] <= 1'b0;
      if (key_low & ~keypad_flag)
        irq_stat[`PAK_IRQ_KEYPAD] <= 1'b1;
      if (T0_OVERFLOW)
        irq_stat[`PAK_IRQ_T0OVF] <= 1'b1;
    end
  end

  always @*
  begin
    for (i = 0; i < 2; i = i + 1)
    begin
      case ({port2_aux_mode[i], port2_mode_second[i]})
        2'b00:
        begin
          next_p2_out[i] = 1'b0;
          next_p2_oe[i]  = ~P2_LATCH[i];
          next_p2_pu[i]  = P2_LATCH[i];
        end
        2'b01:
        begin
          next_p2_out[i] = P2_LATCH[i];
          next_p2_oe[i]  = 1'b1;
          next_p2_pu[i]  = 1'b0;
        end
        2'b11:
        begin
          next_p2_out[i] = 1'b0;
          next_p2_oe[i]  = ~P2_LATCH[i];
          next_p2_pu[i]  = 1'b0;
        end
        default:
        begin
          next_p2_out[i] = 1'b0;
          next_p2_oe[i]  = 1'b0;
          next_p2_pu[i]  = 1'b0;
        end
      endcase
    end
    // clock output takes over pin 0
    if (port2_aux_mode[`PAK_CLOCK_OUT_ENABLE_BIT] & rc_sync)
    begin
      next_p2_out[0] = clk_div_out;
      next_p2_oe[0]  = 1'b1;
      next_p2_pu[0]  = 1'b0;
    end
  end

  // toggle on overflow, pin is open drain so only the low is driven
  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
      t0_toggle <= 1'b1;
    else if (port2_aux_mode[`PAK_TIMER0_TOGGLE_ENABLE_BIT] & T0_OVERFLOW)
      t0_toggle <= ~t0_toggle;
  end

  // Registered pin and status outputs; pin path adds one cycle
  always @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      P2_OUT         <= 2'h0;
      P2_OE          <= 2'h0;
      P2_WEAK_PU     <= 2'h0;
      P1_2_OUT       <= 1'b0;
      P1_2_OE        <= 1'b0;
      SCHMITT_SEL    <= 3'h0;
      KEYPAD_IRQ_REQ <= 1'b0;
      WAKE           <= 1'b0;
      IRQ            <= 1'b0;
    end
    else
    begin
      P2_OUT      <= next_p2_out;
      P2_OE       <= next_p2_oe;
      P2_WEAK_PU  <= next_p2_pu;
      P1_2_OUT    <= 1'b0;
      P1_2_OE     <= port2_aux_mode[`PAK_TIMER0_TOGGLE_ENABLE_BIT] & ~t0_toggle;
      SCHMITT_SEL <= {port2_aux_mode[`PAK_P2S_BIT], port2_aux_mode[`PAK_P1S_BIT],
                      port2_aux_mode[`PAK_P0S_BIT]};
      // request gated by the keypad enable
      KEYPAD_IRQ_REQ <= keypad_flag & keypad_irq_en;
      WAKE <= keypad_flag & keypad_irq_en & (IDLE_MODE | POWER_DOWN);
      IRQ  <= |(irq_stat & irq_mask);
    end
  end

  // clockless power-down wake; async set is a constant, cleared by clock after power-down ends
  always @(posedge REF_CLK or negedge ARST_N or posedge pd_async_low)
  begin
    if (!ARST_N)
      PD_WAKE <= 1'b0;
    else if (pd_async_low)
      PD_WAKE <= 1'b1;
    else if (~POWER_DOWN)
      PD_WAKE <= 1'b0;
  end

endmodule

`default_nettype wire

// *** core/pak_regs.vh ***
`ifndef PAK_REGS_VH
`define PAK_REGS_VH

// Register indices; byte address is four times the index
`define PAK_IDX_KEYPAD_EN   8'h86
`define PAK_IDX_P2_AUX      8'hA4
`define PAK_IDX_P2_MODE2    8'hA5
`define PAK_IDX_AUX_CTRL1   8'hA2
`define PAK_IDX_IRQ_STAT    8'hB0
`define PAK_IDX_IRQ_MASK    8'hB1

// Reset values
`define PAK_RST_KEYPAD_EN   8'h00
`define PAK_RST_P2_AUX      8'h00
`define PAK_RST_P2_MODE2    8'h00
`define PAK_RST_AUX_CTRL1   8'h00
`define PAK_RST_IRQ         2'h0

// Fields of the port-2 auxiliary mode register
`define PAK_P2S_BIT         7
`define PAK_P1S_BIT         6
`define PAK_P0S_BIT         5
`define PAK_CLOCK_OUT_ENABLE_BIT       4
`define PAK_TIMER0_TOGGLE_ENABLE_BIT        2
`define PAK_P2_MODE_MSB     1
`define PAK_P2_MODE_LSB     0

// Keypad enable field and usable bits
`define PAK_KPE_MSB         6
`define PAK_KPE_LSB         3
`define PAK_KPE_MASK        8'h78

// Fields of the auxiliary control register
`define PAK_KBF_BIT         7
`define PAK_KIE_BIT         0

// Interrupt status bits
`define PAK_IRQ_KEYPAD      0
`define PAK_IRQ_T0OVF       1

// Clock output divides the CPU clock by this ratio
`define PAK_CLKOUT_DIV      6

// AXI responses
`define PAK_RESP_OKAY       2'h0
`define PAK_RESP_SLVERR     2'h2

`endif

// *** core/pak_sync.v ***
`timescale 1ns/100ps
`default_nettype none

module pak_sync #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk,
  input  wire         arst_n,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] stage1;

  // Two-stage synchroniser; first stage feeds only the second
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stage1 <= {W{1'b0}};
      q      <= {W{1'b0}};
    end
    else
    begin
      stage1 <= d;
      q      <= stage1;
    end
  end

endmodule

`default_nettype wire

// *** core/pak_clkdiv.v ***
`timescale 1ns/100ps
`default_nettype none
`include "pak_regs.vh"

module pak_clkdiv (
  // Clock and reset
  input  wire clk,
  input  wire arst_n,
  // Control and output
  input  wire enable,
  output reg  clk_out
);

  // Half period in clock edges less one, cut to the counter width on purpose
  localparam integer HALF_FULL = (`PAK_CLKOUT_DIV / 2) - 1;
  localparam [1:0]   HALF      = HALF_FULL[1:0];

  reg [1:0] cnt;

  // Toggle every half period; parked low at once when disabled, which can cut a high half period short
  always @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt     <= 2'h0;
      clk_out <= 1'b0;
    end
    else if (!enable)
    begin
      cnt     <= 2'h0;
      clk_out <= 1'b0;
    end
    else if (cnt == HALF)
    begin
      cnt     <= 2'h0;
      clk_out <= ~clk_out;
    end
    else
    begin
      cnt <= cnt + 2'h1;
    end
  end

endmodule

`default_nettype wire

// *** testbench/pak_sva.sv ***
`timescale 1ns/100ps
`default_nettype none
module pak_sva #(
  parameter AW = 12
) (
  // Clock and reset
  input wire logic        REF_CLK,
  input wire logic        ARST_N,
  // Register bus
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  // Core side and outputs
  input wire logic        IDLE_MODE,
  input wire logic        POWER_DOWN,
  input wire logic        KEYPAD_IRQ_REQ,
  input wire logic        WAKE,
  input wire logic        PD_WAKE,
  input wire logic [2:0]  SCHMITT_SEL
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  // Write takes address and data together, answer two edges later
  sequence s_both_taken;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence s_late_resp;
    !S_AXI_BVALID ##1 S_AXI_BVALID;
  endsequence
  a_write_latency: assert property (s_both_taken |=> s_late_resp)
    else $error("write response timing wrong");
  a_read_latency: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read data late");
  a_bresp_hold: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  a_rdata_hold: assert property (S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  a_aw_refused: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write accepted while answering");
  a_flag_sticky: assert property ($fell(KEYPAD_IRQ_REQ) |-> $past(S_AXI_BVALID))
    else $error("keypad request cleared without a write");
  a_wake_cause: assert property (WAKE |-> KEYPAD_IRQ_REQ && $past(IDLE_MODE || POWER_DOWN))
    else $error("wake without request in low power");
  a_pd_wake_mode: assert property ($rose(PD_WAKE) |-> POWER_DOWN || $past(POWER_DOWN))
    else $error("power-down wake outside power-down");
  a_schmitt_write: assert property ($changed(SCHMITT_SEL) |-> $past(S_AXI_BVALID))
    else $error("input select changed without a write");
endmodule
bind pak_top pak_sva #(.AW(AW)) u_sva (.REF_CLK(REF_CLK), .ARST_N(ARST_N),
  .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
  .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
  .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY), .S_AXI_RDATA(S_AXI_RDATA),
  .IDLE_MODE(IDLE_MODE), .POWER_DOWN(POWER_DOWN), .KEYPAD_IRQ_REQ(KEYPAD_IRQ_REQ),
  .WAKE(WAKE), .PD_WAKE(PD_WAKE), .SCHMITT_SEL(SCHMITT_SEL));
`default_nettype wire

// *** testbench/pak_keypad_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pak_keypad_model (
  // Key closures, one per keypad pin 3 to 6
  input  wire logic [3:0] key_press,
  // Port-0 pin levels
  output wire logic [7:0] p0_level
);
  // Open keys sit at the pull-up level; a closed key shorts its pin low
  assign p0_level = {1'b1, ~key_press, 3'b111};
endmodule
`default_nettype wire

// *** testbench/test_pak_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "pak_regs.vh"
module test_pak_top;
  logic        clk = 0, arst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rd_v;
  logic [3:0]  wstrb = 0, keys = 0;
  logic        idle = 0, pd = 0, t0 = 0, rc = 0;
  logic [1:0]  latch = 2'b01, resp, rresp_v;
  wire logic   awready, wready, bvalid, arready, rvalid, p1_out, p1_oe, kreq, wake, pd_wake, irq;
  wire logic [1:0]  bresp, rresp, p2_out, p2_oe, p2_pu;
  wire logic [31:0] rdata;
  wire logic [2:0]  schmitt;
  wire logic [7:0]  p0;
  int          err_count = 0, comparisons = 0, cycles = 0, n, m;
  // Rows: address, write value, read-back value
  localparam logic [27:0] ROWS [4] = '{28'h218FF78, 28'h290E3E3, 28'h2940303, 28'h2C40303};
  // Output enables per mode pair, latch 01: quasi, push-pull, input only, open drain
  localparam logic [7:0] OE_EXP = 8'h8E;
  // Weak pull-up only in quasi mode with the latch high
  localparam logic [7:0] PU_EXP = 8'h01;

  pak_keypad_model u_keys (.key_press(keys), .p0_level(p0));
  pak_top uut (.REF_CLK(clk), .ARST_N(arst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IDLE_MODE(idle),
    .POWER_DOWN(pd), .T0_OVERFLOW(t0), .P2_LATCH(latch), .P0_PIN(p0), .RC_OSC_SEL(rc),
    .P2_OUT(p2_out), .P2_OE(p2_oe), .P2_WEAK_PU(p2_pu), .P1_2_OUT(p1_out), .P1_2_OE(p1_oe),
    .SCHMITT_SEL(schmitt), .KEYPAD_IRQ_REQ(kreq), .WAKE(wake), .PD_WAKE(pd_wake), .IRQ(irq));

  // 25 MHz clock
  initial
  begin
    forever #20 clk = ~clk;
  end

  // Hang guard, well above the length of the sequence
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      err_count++;
      finish_test;
    end
  end

  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task chk(input string nm, input [31:0] e, input [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Let k edges pass, then sample once outputs have settled
  task tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  // Address and data offered together, each dropped once taken
  task wr(input [11:0] a, input [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hF;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    do
    begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid)
      begin
        resp = bresp;
        bready <= 0;
      end
    end while (!bvalid);
  endtask

  task rd(input [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do
    begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid)
      begin
        rd_v = rdata;
        rresp_v = rresp;
        rready <= 0;
      end
    end while (!rvalid);
  endtask

  // Clock-out pin: cycles until the next rising level
  task rise_wait;
    logic l;
    n = 0;
    do
    begin
      l = p2_out[0];
      tick(1);
      n++;
    end while (!(p2_out[0] && !l) && n < 20);
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1;
    tick(2);
    for (m = 0; m < 4; m++)
    begin
      rd(ROWS[m][27:16]);
      chk("reset value", 0, rd_v);
    end
    chk("schmitt reset", 0, schmitt);
    $display("test reset done");
    for (m = 0; m < 4; m++)
    begin
      wr(ROWS[m][27:16], ROWS[m][15:8]);
      rd(ROWS[m][27:16]);
      chk("register", ROWS[m][7:0], rd_v);
    end
    chk("schmitt select", 3'b111, schmitt);
    wr(12'h2FC, 8'hFF);
    chk("unmapped bresp", `PAK_RESP_SLVERR, resp);
    rd(12'h2FC);
    chk("unmapped rresp", `PAK_RESP_SLVERR, rresp_v);
    $display("test registers done");
    for (m = 0; m < 4; m++)
    begin
      wr(12'h290, 8'hE0 | {6'h0, {2{m[1]}}});
      wr(12'h294, {6'h0, {2{m[0]}}});
      tick(2);
      chk("port2 enable", OE_EXP[2*m+:2], p2_oe);
      chk("port2 pull-up", PU_EXP[2*m+:2], p2_pu);
    end
    $display("test modes done");
    // Keypad: pin 3 enabled only, pin 4 pressed first
    wr(12'h218, 8'h08);
    wr(12'h288, 8'h01);
    @(posedge clk) keys <= 4'b0010;
    tick(6);
    rd(12'h288);
    chk("flag off pin", 8'h01, rd_v);
    @(posedge clk) keys <= 4'b0001;
    tick(6);
    @(posedge clk) keys <= 0;
    tick(6);
    rd(12'h288);
    chk("flag held", 8'h81, rd_v);
    chk("irq request", 1, kreq);
    rd(12'h2C0);
    chk("status", 8'h01, rd_v);
    chk("irq line", 1, irq);
    wr(12'h2C4, 8'h02);
    tick(1);
    chk("irq masked", 0, irq);
    wr(12'h2C4, 8'h03);
    wr(12'h2C0, 8'h01);
    tick(1);
    chk("irq cleared", 0, irq);
    @(posedge clk) idle <= 1;
    tick(2);
    chk("idle wake", 1, wake);
    @(posedge clk) idle <= 0;
    wr(12'h288, 8'h81);
    tick(1);
    chk("flag after one", 1, kreq);
    wr(12'h288, 8'h01);
    tick(1);
    chk("flag cleared", 0, kreq);
    wr(12'h288, 8'h00);
    @(posedge clk) keys <= 4'b0001;
    tick(6);
    rd(12'h288);
    chk("flag disabled", 8'h00, rd_v);
    @(posedge clk) keys <= 0;
    wr(12'h288, 8'h01);
    @(posedge clk) pd <= 1;
    tick(2);
    chk("pd wake idle", 0, pd_wake);
    @(posedge clk) keys <= 4'b0001;
    #5;
    chk("pd wake async", 1, pd_wake);
    tick(6);
    chk("pd wake core", 1, wake);
    @(posedge clk) keys <= 0;
    pd <= 0;
    wr(12'h288, 8'h01);
    wr(12'h2C0, 8'h03);
    $display("test keypad done");
    // Timer toggle on the open-drain pin
    wr(12'h290, 8'hE4);
    tick(2);
    chk("toggle start", 0, p1_oe);
    chk("toggle drive", 0, p1_out);
    for (m = 1; m < 3; m++)
    begin
      @(posedge clk) t0 <= 1;
      @(posedge clk) t0 <= 0;
      tick(3);
      chk("toggle", m[0], p1_oe);
    end
    rd(12'h2C0);
    chk("overflow status", 8'h02, rd_v);
    $display("test toggle done");
    // Clock out with RC strap, kept running in idle
    wr(12'h290, 8'hF0);
    @(posedge clk) rc <= 1;
    idle <= 1;
    tick(6);
    rise_wait;
    rise_wait;
    chk("clock period", `PAK_CLKOUT_DIV, n);
    $display("test clock out done");
    finish_test;
  end
endmodule
`default_nettype wire
